// ==== lane_pkg.sv ====
package lane_pkg;
	// Host interface styles, fixed at configuration time
	typedef enum logic [2:0] {
		STYLE_HIEN_MUX  = 3'h0,
		STYLE_WRHL_MUX  = 3'h1,
		STYLE_SIZE_NMUX = 3'h2,
		STYLE_ULSTB_NMUX = 3'h3,
		STYLE_BURST_MUX = 3'h4,
		STYLE_WRHL_NMUX = 3'h5
	} host_style_t;

	localparam int  ADDR_W        = 20;
	localparam int  DATA_W        = 16;
	localparam int  BYTE_W        = 8;
	localparam int  LANE_CNT      = 2;
	localparam int  LANE_HI       = 1;
	localparam int  LANE_LO       = 0;
	localparam int  BURST_LO_BIT  = 1;
	localparam int  BURST_HI_BIT  = 3;
	localparam int  BURST_BYTES   = 16;
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} cycle_state_t;
endpackage

// ==== lane_if.sv ====
`timescale 1ns/100ps
interface lane_if;
	logic       lane_hi;
	logic       lane_lo;
	logic       odd_on_hi;
	logic [2:0] style;
	logic       a0;
	logic       ctl0_n;
	logic       ctl1_n;
	logic       ctl2_n;
	logic       pd3_n;
	modport dec (input style, a0, ctl0_n, ctl1_n, ctl2_n, pd3_n,
		output lane_hi, lane_lo, odd_on_hi);
	modport use_side (output style, a0, ctl0_n, ctl1_n, ctl2_n, pd3_n,
		input lane_hi, lane_lo, odd_on_hi);
endinterface

// ==== lane_decode.sv ====
`timescale 1ns/100ps
module lane_decode (
	lane_if.dec l
);
	import lane_pkg::*;
	always_comb begin
		l.lane_hi   = 1'b0;
		l.lane_lo   = 1'b0;
		l.odd_on_hi = 1'b1;
		case (l.style)
			STYLE_HIEN_MUX: begin
				l.lane_hi = ~l.ctl2_n;
				l.lane_lo = ~l.a0;
			end
			STYLE_WRHL_MUX, STYLE_BURST_MUX, STYLE_WRHL_NMUX: begin
				l.lane_hi = ~l.pd3_n;
				l.lane_lo = ~l.ctl0_n;
			end
			STYLE_SIZE_NMUX: begin
				l.odd_on_hi = 1'b0;
				l.lane_hi   = ~l.a0;
				l.lane_lo   = ~l.ctl2_n | l.a0;
			end
			STYLE_ULSTB_NMUX: begin
				l.odd_on_hi = 1'b0;
				l.lane_hi   = ~l.ctl1_n;
				l.lane_lo   = ~l.ctl2_n;
			end
			default: begin
				l.lane_hi = 1'b0;
				l.lane_lo = 1'b0;
			end
		endcase
	end
endmodule

// ==== host_port.sv ====
// How it works
// - Address bit 0 low means even byte, high means odd byte.
// - Byte-high-enable mode: enable and A0 pick word, odd-high or even-low lanes.
// - Split write strobes: high strobe upper lane odd, low strobe lower lane even.
// - Size-bit mode: size 0 with A0 low word, otherwise A0 picks even-high or odd-low.
// - Upper/lower data strobes: upper selects even-high lane, lower odd-low lane.
// - Non-multiplexed data: low byte on port F, high byte on port G.
// - Size style: control 0 read/write, 1 data strobe, 2 size bit.
// - Multiplexed without enable: low write on control 0, high on port D bit 3.
// - Burst: upper address latched, low bits 3..1 fetch up to 16 bytes.
// - Burst host: bits 3..1 separate, bits 19..4 shared with data.
// - Burst host: read on control 1, program enable control 2, write strobes split.
// - Non-multiplexed: address strobe optional, used when latching addresses.
// - Byte-enable host: read/write control 0, enables on control 1 and 2.
// - Byte enables as write strobes: output-enable, low write, high write decoding.
// - Multiplexed write/read/enable/latch and read/low/high/latch control sets supported.
// - Multiplexed: latch address on strobe, drive bus only on selected read.
// - Non-multiplexed: ports F and G undriven unless the host accesses.
`timescale 1ns/100ps
module host_port (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	// Configuration
	input  wire lane_pkg::host_style_t         host_style,
	input  wire logic                          addr_latch_used,
	// Host control pins
	input  wire logic                          address_latch_strobe,
	input  wire logic                          ctrl_in_0,
	input  wire logic                          ctrl_in_1,
	input  wire logic                          ctrl_in_2,
	input  wire logic                          port_d_bit3,
	input  wire logic                          chip_select,
	// Shared address/data port
	input  wire logic [lane_pkg::DATA_W-1:0]   shared_addr_data_port_in,
	output logic      [lane_pkg::DATA_W-1:0]   shared_addr_data_port_out,
	output logic                               shared_addr_data_port_oe,
	// Non-multiplexed low address bits
	input  wire logic [lane_pkg::BURST_HI_BIT:0] low_addr_in,
	// Data ports F (low byte) and G (high byte)
	input  wire logic [lane_pkg::BYTE_W-1:0]   port_f_in,
	input  wire logic [lane_pkg::BYTE_W-1:0]   port_g_in,
	output logic      [lane_pkg::BYTE_W-1:0]   port_f_out,
	output logic      [lane_pkg::BYTE_W-1:0]   port_g_out,
	output logic                               port_f_oe,
	output logic                               port_g_oe,
	// Internal memory side
	output logic      [lane_pkg::ADDR_W-1:0]   mem_addr,
	output logic                               mem_wr_even,
	output logic                               mem_wr_odd,
	output logic      [lane_pkg::BYTE_W-1:0]   mem_wdata_even,
	output logic      [lane_pkg::BYTE_W-1:0]   mem_wdata_odd,
	input  wire logic [lane_pkg::BYTE_W-1:0]   mem_rdata_even,
	input  wire logic [lane_pkg::BYTE_W-1:0]   mem_rdata_odd
);
	import lane_pkg::*;

	lane_if lif ();

	logic                muxed;
	logic                split_wr;
	logic                rd_act;
	logic                wr_act;
	logic                a0;
	logic                both_lanes;
	logic [BYTE_W-1:0]   rd_hi;
	logic [BYTE_W-1:0]   rd_lo;
	logic [ADDR_W-1:0]   addr_ff;
	logic [ADDR_W-1:0]   nxt_addr;
	logic                wr_prev_ff;
	logic                nxt_wr_prev;
	logic [DATA_W-1:0]   wdata_ff;
	logic [DATA_W-1:0]   nxt_wdata;
	logic                lane_hi_ff;
	logic                nxt_lane_hi;
	logic                lane_lo_ff;
	logic                nxt_lane_lo;
	logic                odd_hi_ff;
	logic                nxt_odd_hi;
	logic [DATA_W-1:0]   rdata_ff;
	logic [DATA_W-1:0]   nxt_rdata;
	cycle_state_t        state_ff;
	cycle_state_t        nxt_state;

	lane_decode u_dec (
		.l (lif.dec)
	);

	// Control pin roles per host style
	always_comb begin
		muxed  = (host_style == STYLE_HIEN_MUX) || (host_style == STYLE_WRHL_MUX)
			|| (host_style == STYLE_BURST_MUX);
		split_wr = (host_style == STYLE_WRHL_MUX) || (host_style == STYLE_BURST_MUX)
			|| (host_style == STYLE_WRHL_NMUX);
		rd_act = 1'b0;
		wr_act = 1'b0;
		case (host_style)
			STYLE_HIEN_MUX: begin
				rd_act = ~ctrl_in_1;
				wr_act = ~ctrl_in_0;
			end
			STYLE_WRHL_MUX, STYLE_BURST_MUX, STYLE_WRHL_NMUX: begin
				rd_act = ~ctrl_in_1 | ((host_style == STYLE_BURST_MUX) & ~ctrl_in_2);
				wr_act = ~ctrl_in_0 | ~port_d_bit3;
			end
			STYLE_SIZE_NMUX, STYLE_ULSTB_NMUX: begin
				rd_act = ~ctrl_in_1 & ctrl_in_0;
				wr_act = ~ctrl_in_1 & ~ctrl_in_0;
				if (host_style == STYLE_ULSTB_NMUX) begin
					rd_act = (~ctrl_in_1 | ~ctrl_in_2) & ctrl_in_0;
					wr_act = (~ctrl_in_1 | ~ctrl_in_2) & ~ctrl_in_0;
				end
			end
			default: begin
				rd_act = 1'b0;
				wr_act = 1'b0;
			end
		endcase
		rd_act = rd_act & chip_select;
		wr_act = wr_act & chip_select;
	end

	// Address capture
	always_comb begin
		nxt_addr = addr_ff;
		if (muxed) begin
			if (address_latch_strobe)
				nxt_addr = {shared_addr_data_port_in, low_addr_in};
			else if (host_style == STYLE_BURST_MUX)
				nxt_addr = {addr_ff[ADDR_W-1:BURST_HI_BIT+1], low_addr_in[BURST_HI_BIT:1],
					low_addr_in[0]};
		end else if (!addr_latch_used || address_latch_strobe) begin
			nxt_addr = {shared_addr_data_port_in, low_addr_in};
		end
		a0 = nxt_addr[0];
	end

	assign lif.style  = host_style;
	assign lif.a0     = a0;
	assign lif.ctl0_n = ctrl_in_0;
	assign lif.ctl1_n = ctrl_in_1;
	assign lif.ctl2_n = ctrl_in_2;
	assign lif.pd3_n  = port_d_bit3;
	assign both_lanes = lif.lane_hi & lif.lane_lo;

	// Cycle state, write data and read data capture
	always_comb begin
		nxt_state   = state_ff;
		nxt_wr_prev = wr_act;
		nxt_wdata   = wdata_ff;
		nxt_lane_hi = lane_hi_ff;
		nxt_lane_lo = lane_lo_ff;
		nxt_odd_hi  = odd_hi_ff;
		nxt_rdata   = rdata_ff;
		rd_hi = lif.odd_on_hi ? mem_rdata_odd : mem_rdata_even;
		rd_lo = lif.odd_on_hi ? mem_rdata_even : mem_rdata_odd;
		case (state_ff)
			ST_IDLE: begin
				if (rd_act)
					nxt_state = ST_READ;
				else if (wr_act)
					nxt_state = ST_WRITE;
			end
			ST_READ: begin
				if (!rd_act)
					nxt_state = ST_IDLE;
			end
			ST_WRITE: begin
				if (!wr_act)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (rd_act) begin
			// Split write strobes carry no lane choice, so reads are word reads
			nxt_lane_hi = lif.lane_hi | split_wr;
			nxt_lane_lo = lif.lane_lo | split_wr;
			nxt_rdata   = {rd_hi, rd_lo};
		end
		if (wr_act) begin
			nxt_lane_hi = lif.lane_hi;
			nxt_lane_lo = lif.lane_lo;
			nxt_odd_hi  = lif.odd_on_hi;
			nxt_wdata   = muxed ? shared_addr_data_port_in : {port_g_in, port_f_in};
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_ff   <= ST_IDLE;
			addr_ff    <= ADDR_RST;
			wr_prev_ff <= 1'b0;
			wdata_ff   <= DATA_RST;
			lane_hi_ff <= 1'b0;
			lane_lo_ff <= 1'b0;
			odd_hi_ff  <= 1'b1;
			rdata_ff   <= DATA_RST;
		end else begin
			state_ff   <= nxt_state;
			addr_ff    <= nxt_addr;
			wr_prev_ff <= nxt_wr_prev;
			wdata_ff   <= nxt_wdata;
			lane_hi_ff <= nxt_lane_hi;
			lane_lo_ff <= nxt_lane_lo;
			odd_hi_ff  <= nxt_odd_hi;
			rdata_ff   <= nxt_rdata;
		end
	end

	// Writes commit on the trailing edge of the write strobe
	always_comb begin
		mem_addr       = addr_ff;
		mem_wr_odd     = wr_prev_ff & ~wr_act & (odd_hi_ff ? lane_hi_ff : lane_lo_ff);
		mem_wr_even    = wr_prev_ff & ~wr_act & (odd_hi_ff ? lane_lo_ff : lane_hi_ff);
		mem_wdata_odd  = odd_hi_ff ? wdata_ff[DATA_W-1:BYTE_W] : wdata_ff[BYTE_W-1:0];
		mem_wdata_even = odd_hi_ff ? wdata_ff[BYTE_W-1:0] : wdata_ff[DATA_W-1:BYTE_W];
	end

	// Read drive
	always_comb begin
		shared_addr_data_port_out = rdata_ff;
		shared_addr_data_port_oe  = muxed & (state_ff == ST_READ) & rd_act
			& (lane_hi_ff | lane_lo_ff);
		port_g_out = rdata_ff[DATA_W-1:BYTE_W];
		port_f_out = rdata_ff[BYTE_W-1:0];
		port_g_oe  = ~muxed & (state_ff == ST_READ) & rd_act & lane_hi_ff;
		port_f_oe  = ~muxed & (state_ff == ST_READ) & rd_act & lane_lo_ff;
	end

	chk_word_write: assert property (@(posedge core_clk) disable iff (reset)
		(wr_act && both_lanes && host_style == STYLE_WRHL_NMUX) ##1 !wr_act
		|-> mem_wr_odd && mem_wr_even)
		else $error("word write missed a lane");
	chk_no_lane_write: assert property (@(posedge core_clk) disable iff (reset)
		(mem_wr_odd || mem_wr_even) |-> $past(wr_act) && !wr_act)
		else $error("write outside strobe end");
	chk_nmux_idle_hiz: assert property (@(posedge core_clk) disable iff (reset)
		!rd_act |-> !port_f_oe && !port_g_oe)
		else $error("data ports driven while idle");
	chk_mux_read_drive: assert property (@(posedge core_clk) disable iff (reset)
		shared_addr_data_port_oe |-> muxed && rd_act && chip_select)
		else $error("shared bus driven without read");
	chk_latch_addr: assert property (@(posedge core_clk) disable iff (reset)
		(muxed && address_latch_strobe) |=> mem_addr[ADDR_W-1:BURST_HI_BIT+1]
		== $past(shared_addr_data_port_in))
		else $error("address not latched");
	chk_burst_hold: assert property (@(posedge core_clk) disable iff (reset)
		(host_style == STYLE_BURST_MUX && !address_latch_strobe) |=>
		$stable(mem_addr[ADDR_W-1:BURST_HI_BIT+1]))
		else $error("burst upper address moved");
	chk_size_lane: assert property (@(posedge core_clk) disable iff (reset)
		(host_style == STYLE_SIZE_NMUX && ctrl_in_2 && a0) |-> !lif.lane_hi && lif.lane_lo)
		else $error("size mode odd lane wrong");
	chk_hien_lane: assert property (@(posedge core_clk) disable iff (reset)
		(host_style == STYLE_HIEN_MUX && ctrl_in_2 && !a0) |-> !lif.lane_hi && lif.lane_lo)
		else $error("enable mode even lane wrong");
endmodule

// ==== host_mcu_model.sv ====
`timescale 1ns/100ps
module host_mcu_model (
	// Clock
	input  wire logic        core_clk,
	// Host strobes
	output logic             address_latch_strobe,
	output logic             ctrl_in_0,
	output logic             ctrl_in_1,
	output logic             ctrl_in_2,
	output logic             port_d_bit3,
	output logic             chip_select,
	// Address and data
	output logic [15:0]      bus_ad,
	output logic [3:0]       low_addr,
	output logic [7:0]       port_f,
	output logic [7:0]       port_g
);
	initial begin
		{ctrl_in_0, ctrl_in_1, ctrl_in_2, port_d_bit3} = 4'hf;
		address_latch_strobe = 1'b0;
		chip_select = 1'b0;
		bus_ad = 16'h0000;
		low_addr = 4'h0;
		{port_g, port_f} = 16'h0000;
	end
	// Address phase on the shared pins
	task automatic latch(input logic [15:0] a);
		@(posedge core_clk);
		address_latch_strobe <= 1'b1;
		bus_ad <= a;
		@(posedge core_clk);
		address_latch_strobe <= 1'b0;
		bus_ad <= ~a;
	endtask
	// Strobes in order ctrl_in_0, ctrl_in_1, ctrl_in_2, port_d_bit3
	task automatic start(input logic [3:0] ctl, input logic cs, input logic [3:0] la,
		input logic [15:0] d);
		@(posedge core_clk);
		{ctrl_in_0, ctrl_in_1, ctrl_in_2, port_d_bit3} <= ctl;
		chip_select <= cs;
		low_addr <= la;
		bus_ad <= d;
		{port_g, port_f} <= d;
	endtask
	// Released data lines stop showing the last value
	task automatic stop();
		@(posedge core_clk);
		{ctrl_in_0, ctrl_in_1, ctrl_in_2, port_d_bit3} <= 4'hf;
		chip_select <= 1'b0;
		bus_ad <= ~bus_ad;
		{port_g, port_f} <= ~{port_g, port_f};
	endtask
endmodule

// ==== tb_mcu_byte_lane_host_port.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_mcu_byte_lane_host_port;
	import lane_pkg::*;
	logic        core_clk   = 1'b0;
	logic        reset      = 1'b1;
	host_style_t style      = STYLE_WRHL_NMUX;
	logic        ale, c0, c1, c2, pd3, cs, ad_oe, pf_oe, pg_oe, wr_e, wr_o;
	logic [15:0] ad, ad_out;
	logic [3:0]  la;
	logic [7:0]  pf, pg, pf_out, pg_out, wd_e, wd_o, ev_d, od_d;
	logic [19:0] maddr;
	logic [7:0]  rd_e       = 8'h5a;
	logic [7:0]  rd_o       = 8'hc4;
	int          error_cnt  = 0;
	int          num_checks = 0;
	int          ev_cnt, od_cnt;
	always #25 core_clk = ~core_clk;
	host_port u_host_port (
		.core_clk(core_clk), .reset(reset), .host_style(style), .addr_latch_used(1'b0),
		.address_latch_strobe(ale), .ctrl_in_0(c0), .ctrl_in_1(c1), .ctrl_in_2(c2),
		.port_d_bit3(pd3), .chip_select(cs), .shared_addr_data_port_in(ad),
		.shared_addr_data_port_out(ad_out), .shared_addr_data_port_oe(ad_oe),
		.low_addr_in(la), .port_f_in(pf), .port_g_in(pg), .port_f_out(pf_out),
		.port_g_out(pg_out), .port_f_oe(pf_oe), .port_g_oe(pg_oe), .mem_addr(maddr),
		.mem_wr_even(wr_e), .mem_wr_odd(wr_o), .mem_wdata_even(wd_e), .mem_wdata_odd(wd_o),
		.mem_rdata_even(rd_e), .mem_rdata_odd(rd_o));
	host_mcu_model u_host_mcu_model (
		.core_clk(core_clk), .address_latch_strobe(ale), .ctrl_in_0(c0), .ctrl_in_1(c1),
		.ctrl_in_2(c2), .port_d_bit3(pd3), .chip_select(cs), .bus_ad(ad), .low_addr(la),
		.port_f(pf), .port_g(pg));
	// Tally of write pulses per lane
	always @(posedge core_clk) begin
		if (wr_e === 1'b1) begin
			ev_cnt++;
			ev_d = wd_e;
		end
		if (wr_o === 1'b1) begin
			od_cnt++;
			od_d = wd_o;
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] ctl, input logic cs, input logic [3:0] la,
		input logic [15:0] d, input int ne, input int no, input logic [7:0] ed, od);
		ev_cnt = 0;
		od_cnt = 0;
		ev_d = 8'h00;
		od_d = 8'h00;
		u_host_mcu_model.start(ctl, cs, la, d);
		repeat (2) @(posedge core_clk);
		u_host_mcu_model.stop();
		repeat (3) @(posedge core_clk);
		`CHK(ev_cnt, ne)
		`CHK(od_cnt, no)
		`CHK(ev_d, ed)
		`CHK(od_d, od)
	endtask
	task automatic rd(input logic [3:0] ctl, input logic [15:0] e_ad, input logic e_ao,
		input logic [7:0] e_g, e_f, input logic e_go, e_fo);
		u_host_mcu_model.start(ctl, 1'b1, 4'h0, 16'h0f0f);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK({ad_oe, pg_oe, pf_oe}, {e_ao, e_go, e_fo})
		if (e_ao) `CHK(ad_out, e_ad)
		if (e_go) `CHK(pg_out, e_g)
		if (e_fo) `CHK(pf_out, e_f)
		u_host_mcu_model.stop();
		#1;
		`CHK({ad_oe, pg_oe, pf_oe}, 3'h0)
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		wr(4'h6, 1'b1, 4'h0, 16'hb1a2, 1, 1, 8'ha2, 8'hb1);
		wr(4'he, 1'b1, 4'h1, 16'hb1a2, 0, 1, 8'h00, 8'hb1);
		wr(4'h7, 1'b1, 4'h0, 16'hb1a2, 1, 0, 8'ha2, 8'h00);
		wr(4'h6, 1'b0, 4'h0, 16'hb1a2, 0, 0, 8'h00, 8'h00);
		rd(4'hb, 16'h0000, 1'b0, 8'hc4, 8'h5a, 1'b1, 1'b1);
		@(posedge core_clk) style <= STYLE_SIZE_NMUX;
		wr(4'h1, 1'b1, 4'h0, 16'hd3e4, 1, 1, 8'hd3, 8'he4);
		wr(4'h3, 1'b1, 4'h0, 16'hd3e4, 1, 0, 8'hd3, 8'h00);
		wr(4'h3, 1'b1, 4'h1, 16'hd3e4, 0, 1, 8'h00, 8'he4);
		@(posedge core_clk) style <= STYLE_ULSTB_NMUX;
		wr(4'h1, 1'b1, 4'h0, 16'h6c7d, 1, 1, 8'h6c, 8'h7d);
		wr(4'h3, 1'b1, 4'h0, 16'h6c7d, 1, 0, 8'h6c, 8'h00);
		wr(4'h5, 1'b1, 4'h0, 16'h6c7d, 0, 1, 8'h00, 8'h7d);
		wr(4'h7, 1'b1, 4'h0, 16'h6c7d, 0, 0, 8'h00, 8'h00);
		rd(4'hb, 16'h0000, 1'b0, 8'h5a, 8'h00, 1'b1, 1'b0);
		@(posedge core_clk) style <= STYLE_WRHL_MUX;
		u_host_mcu_model.latch(16'h1230);
		wr(4'he, 1'b1, 4'h0, 16'h9e8f, 0, 1, 8'h00, 8'h9e);
		rd(4'hb, 16'hc45a, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
		@(posedge core_clk) style <= STYLE_BURST_MUX;
		u_host_mcu_model.latch(16'h4560);
		rd(4'hd, 16'hc45a, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
		rd(4'hb, 16'hc45a, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0);
		@(posedge core_clk) style <= STYLE_HIEN_MUX;
		wr(4'h4, 1'b1, 4'h0, 16'h2b3c, 1, 1, 8'h3c, 8'h2b);
		wr(4'h6, 1'b1, 4'h0, 16'h2b3c, 1, 0, 8'h3c, 8'h00);
		test_done();
	end
endmodule
